// File: design/hes_map.svh
// status and reason code values and timing counts for the status selector
`ifndef HES_MAP_SVH
`define HES_MAP_SVH
`define HES_ST_OK          8'h00
`define HES_ST_SCO_MAX     8'h0A
`define HES_ST_ACL_EXISTS  8'h0B
`define HES_ST_DISALLOWED  8'h0C
`define HES_RJ_LO          8'h0D
`define HES_RJ_HI          8'h0F
`define HES_RS_HOST_TMO    8'h10
`define HES_ST_UNSUPPORTED 8'h11
`define HES_ST_INVALID     8'h12
`define HES_DC_LO          8'h13
`define HES_DC_HI          8'h15
`define HES_RS_LOCAL_TERM  8'h16
`define HES_ST_REPEATED    8'h17
`define HES_ST_NO_PAIRING  8'h18
`define HES_ST_NO_RFEAT    8'h1A
`define HES_ST_UNSPEC      8'h1F
`define HES_ST_LMP_PARAM   8'h20
`define HES_CLK_HZ         10_000_000
`define HES_ACCEPT_TIME_US 5000
`define HES_ACCEPT_CYCLES  (`HES_ACCEPT_TIME_US * (`HES_CLK_HZ / 1_000_000))
`endif

// File: design/hes_pkg.sv
// types shared by the status selector and its helpers
`default_nettype none
package hes_pkg;
  typedef enum logic [3:0] {
    CK_OTHER      = 4'b0000,
    CK_RESET      = 4'b0001,
    CK_ADD_SCO    = 4'b0010,
    CK_CREATE     = 4'b0011,
    CK_ACCEPT     = 4'b0100,
    CK_REJECT     = 4'b0101,
    CK_DISCONNECT = 4'b0110,
    CK_RESPONSE   = 4'b0111,
    CK_REMOTE     = 4'b1000
  } hes_cmd_kind_t;
  typedef enum logic [2:0] {
    EV_CMD_COMPLETE  = 3'b000,
    EV_CMD_STATUS    = 3'b001,
    EV_CONN_COMPLETE = 3'b010,
    EV_DISC_COMPLETE = 3'b011,
    EV_AUTH_COMPLETE = 3'b100,
    EV_ASSOC         = 3'b101
  } hes_evt_kind_t;
  typedef enum logic [2:0] {
    LK_CONN_REQ     = 3'b000,
    LK_REPEATED     = 3'b001,
    LK_PAIR_REFUSED = 3'b010,
    LK_NO_FEATURE   = 3'b011,
    LK_LMP_ERROR    = 3'b100,
    LK_DONE         = 3'b101
  } hes_link_kind_t;
  typedef enum logic [1:0] {
    RT_DIRECT      = 2'b00,
    RT_STATUS_THEN = 2'b01,
    RT_STATUS_OK   = 2'b10
  } hes_route_t;
  typedef struct packed {
    logic          valid;
    hes_cmd_kind_t kind;
    logic          cc_cmd;
    logic          len_ok;
    logic          value_ok;
    logic          hw_ok;
    logic          needs_acl;
    logic          handle_sco;
    logic          exec_fail;
    logic [47:0]   addr;
    logic [7:0]    reason;
  } hes_cmd_t;
  typedef struct packed {
    logic           valid;
    hes_link_kind_t kind;
    logic           in_setup;
    logic [7:0]     lmp_code;
    logic [47:0]    addr;
  } hes_link_t;
  typedef struct packed {
    logic          valid;
    hes_evt_kind_t kind;
    logic [7:0]    status;
  } hes_evt_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] reason;
  } hes_air_t;
  typedef struct packed {
    hes_route_t    route;
    logic          use_cc;
    logic [7:0]    code;
    hes_evt_kind_t follow_kind;
    logic [7:0]    follow_code;
    logic          air_valid;
    logic [7:0]    air_reason;
  } hes_verdict_t;
endpackage
`default_nettype wire

// File: design/hes_cmd_check.sv
// combinational verdict on one host command: status code and event route
`default_nettype none
`include "hes_map.svh"
module hes_cmd_check #(
  parameter bit DEFER_CONN_ERR = 1'b0
) (
  input  wire hes_pkg::hes_cmd_t  cmd,
  input  wire logic               restricted,
  input  wire logic               addr_pending,
  input  wire logic               sco_limit,
  input  wire logic               acl_exists,
  output var hes_pkg::hes_verdict_t verdict
);
  // commands still accepted while only replies are expected
  function automatic logic allowed(input hes_pkg::hes_cmd_kind_t k);
    allowed = (k == hes_pkg::CK_ACCEPT) || (k == hes_pkg::CK_REJECT) ||
              (k == hes_pkg::CK_RESPONSE);
  endfunction

  function automatic logic in_range(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ordered checks, first failing one decides the code
  always_comb begin
    verdict             = '0;
    verdict.route       = hes_pkg::RT_DIRECT;
    verdict.use_cc      = cmd.cc_cmd;
    verdict.code        = `HES_ST_OK;
    verdict.follow_kind = hes_pkg::EV_CONN_COMPLETE;
    if (cmd.kind == hes_pkg::CK_RESET) begin
      verdict.use_cc = 1'b1;
    end else if (restricted && !allowed(cmd.kind)) begin
      verdict.code = `HES_ST_DISALLOWED;
    end else if (!cmd.len_ok || !cmd.value_ok) begin
      verdict.code = `HES_ST_INVALID;
    end else if (cmd.needs_acl && cmd.handle_sco) begin
      verdict.code = `HES_ST_INVALID;
    end else if (allowed(cmd.kind) && !addr_pending) begin
      verdict.code = `HES_ST_INVALID;
    end else if (!cmd.hw_ok) begin
      verdict.code = `HES_ST_UNSUPPORTED;
    end else if (cmd.exec_fail) begin
      verdict.code = `HES_ST_UNSPEC;
    end else begin
      unique case (cmd.kind)
        hes_pkg::CK_ADD_SCO, hes_pkg::CK_CREATE: begin
          verdict.route = hes_pkg::RT_STATUS_OK;
          if ((cmd.kind == hes_pkg::CK_ADD_SCO && sco_limit) ||
              (cmd.kind == hes_pkg::CK_CREATE && acl_exists)) begin
            verdict.code        = (cmd.kind == hes_pkg::CK_ADD_SCO) ?
                                  `HES_ST_SCO_MAX : `HES_ST_ACL_EXISTS;
            verdict.follow_code = verdict.code;
            verdict.use_cc      = 1'b0;
            verdict.route       = DEFER_CONN_ERR ? hes_pkg::RT_STATUS_THEN
                                                 : hes_pkg::RT_DIRECT;
          end
        end
        hes_pkg::CK_REJECT: begin
          if (in_range(cmd.reason, `HES_RJ_LO, `HES_RJ_HI)) begin
            verdict.route       = hes_pkg::RT_STATUS_THEN;
            verdict.follow_code = cmd.reason;
            verdict.air_valid   = 1'b1;
            verdict.air_reason  = cmd.reason;
          end else begin
            verdict.code = `HES_ST_INVALID;
          end
        end
        hes_pkg::CK_DISCONNECT: begin
          if (in_range(cmd.reason, `HES_DC_LO, `HES_DC_HI) ||
              cmd.reason == `HES_ST_NO_RFEAT) begin
            verdict.route       = hes_pkg::RT_STATUS_THEN;
            verdict.follow_kind = hes_pkg::EV_DISC_COMPLETE;
            verdict.follow_code = `HES_RS_LOCAL_TERM;
            verdict.air_valid   = 1'b1;
            verdict.air_reason  = cmd.reason;
          end else begin
            verdict.code = `HES_ST_INVALID;
          end
        end
        hes_pkg::CK_ACCEPT, hes_pkg::CK_REMOTE: begin
          verdict.route = hes_pkg::RT_STATUS_OK;
        end
        default: begin
          verdict.route = hes_pkg::RT_DIRECT;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: design/hes_conn_tracker.sv
// pending incoming connection request and its accept timer
`default_nettype none
module hes_conn_tracker #(
  parameter int unsigned ACCEPT_CYCLES = 50000
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        req_set,
  input  wire logic [47:0] req_addr,
  input  wire logic        req_clr,
  input  wire logic        tmo_ack,
  output logic             pending_r,
  output logic [47:0]      pend_addr_r,
  output logic             tmo_req_r
);
  localparam int CW = $clog2(ACCEPT_CYCLES + 1);
  logic [CW-1:0] count_r;
  logic          expire;

  initial begin
    if (ACCEPT_CYCLES < 1) $error("accept timer needs at least one cycle");
  end

  assign expire = pending_r && (count_r == '0) && !req_set && !req_clr;

  // request flag, a new request wins over a reply in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pending_r <= 1'b0;
    end else if (req_set) begin
      pending_r <= 1'b1;
    end else if (req_clr || expire) begin
      pending_r <= 1'b0;
    end
  end

  // address of the device whose request is outstanding
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_addr_r <= 48'h0000_0000_0000;
    end else if (req_set) begin
      pend_addr_r <= req_addr;
    end
  end

  // accept timer counts down while a request is outstanding
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
    end else if (req_set) begin
      count_r <= CW'(ACCEPT_CYCLES - 1);
    end else if (pending_r && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  // expiry stays raised until taken; a fresh expiry wins over the ack
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tmo_req_r <= 1'b0;
    end else if (expire) begin
      tmo_req_r <= 1'b1;
    end else if (tmo_ack) begin
      tmo_req_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/hes_status_select.sv
// status and reason code selection for returned events and over-air reasons
`default_nettype none
`include "hes_map.svh"
module hes_status_select #(
  parameter int unsigned ACCEPT_CYCLES  = `HES_ACCEPT_CYCLES,
  parameter bit          DEFER_CONN_ERR = 1'b0
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire hes_pkg::hes_cmd_t  cmd_in,
  output logic                   cmd_ready_r,
  input  wire hes_pkg::hes_link_t link_in,
  output logic                   link_ready_r,
  input  wire logic              restricted,
  input  wire logic              sco_limit,
  input  wire logic              acl_exists,
  output var hes_pkg::hes_evt_t  evt_r,
  output var hes_pkg::hes_air_t  air_r,
  output logic                   conn_pending_r
);
  hes_pkg::hes_verdict_t verdict;
  hes_pkg::hes_evt_t     evt_nxt;
  hes_pkg::hes_air_t     air_nxt;
  hes_pkg::hes_evt_t     fol_evt_r;
  hes_pkg::hes_evt_t     fol_evt_nxt;
  hes_pkg::hes_air_t     fol_air_r;
  hes_pkg::hes_air_t     fol_air_nxt;
  logic                  follow_r;
  logic                  follow_nxt;
  logic                  link_turn_r;
  logic                  take_cmd;
  logic                  take_link;
  logic                  tmo_req;
  logic                  tmo_ack;
  logic                  sel_link;
  logic                  free;
  logic                  addr_pending;
  logic                  req_clr;
  logic [47:0]           pend_addr;
  logic                  pending;

  initial begin
    if (ACCEPT_CYCLES < 1) $error("accept timer too short");
  end

  // map one remote link result onto the event returned to the host
  function automatic hes_pkg::hes_evt_t link_evt(
    input hes_pkg::hes_link_t l
  );
    link_evt       = '0;
    link_evt.valid = 1'b1;
    link_evt.kind  = hes_pkg::EV_ASSOC;
    unique case (l.kind)
      hes_pkg::LK_CONN_REQ: begin
        link_evt.valid = 1'b0;
      end
      hes_pkg::LK_REPEATED: begin
        link_evt.kind   = l.in_setup ? hes_pkg::EV_CONN_COMPLETE
                                     : hes_pkg::EV_AUTH_COMPLETE;
        link_evt.status = `HES_ST_REPEATED;
      end
      hes_pkg::LK_PAIR_REFUSED: begin
        link_evt.kind   = l.in_setup ? hes_pkg::EV_CONN_COMPLETE
                                     : hes_pkg::EV_AUTH_COMPLETE;
        link_evt.status = `HES_ST_NO_PAIRING;
      end
      hes_pkg::LK_NO_FEATURE: begin
        link_evt.status = `HES_ST_NO_RFEAT;
      end
      hes_pkg::LK_LMP_ERROR: begin
        link_evt.status = (l.lmp_code == `HES_ST_LMP_PARAM) ?
                          `HES_ST_LMP_PARAM : `HES_ST_UNSPEC;
      end
      hes_pkg::LK_DONE: begin
        link_evt.status = `HES_ST_OK;
      end
      default: begin
        link_evt.status = `HES_ST_UNSPEC;
      end
    endcase
  endfunction

  // handshakes: a request is taken only while its ready is high
  assign take_cmd  = cmd_in.valid && cmd_ready_r;
  assign take_link = link_in.valid && link_ready_r;

  // accept timer expiry goes out once nothing else owns the output
  assign tmo_ack = tmo_req && !follow_r && !take_cmd && !take_link;

  // a reply only counts when it names the device that asked
  assign addr_pending = pending && (cmd_in.addr == pend_addr);

  // accept or reject that passed every check ends the pending request
  assign req_clr = take_cmd && verdict.code == `HES_ST_OK &&
                   (cmd_in.kind == hes_pkg::CK_ACCEPT ||
                    cmd_in.kind == hes_pkg::CK_REJECT);

  hes_cmd_check #(
    .DEFER_CONN_ERR (DEFER_CONN_ERR)
  ) u_check (
    .cmd          (cmd_in),
    .restricted   (restricted || pending),
    .addr_pending (addr_pending),
    .sco_limit    (sco_limit),
    .acl_exists   (acl_exists),
    .verdict      (verdict)
  );

  hes_conn_tracker #(
    .ACCEPT_CYCLES (ACCEPT_CYCLES)
  ) u_track (
    .clock       (clock),
    .rst_b       (rst_b),
    .req_set     (take_link && link_in.kind == hes_pkg::LK_CONN_REQ),
    .req_addr    (link_in.addr),
    .req_clr     (req_clr),
    .tmo_ack     (tmo_ack),
    .pending_r   (pending),
    .pend_addr_r (pend_addr),
    .tmo_req_r   (tmo_req)
  );

  // choose the next event: follow-up, then timeout, then link, then command
  always_comb begin
    evt_nxt     = '0;
    air_nxt     = '0;
    follow_nxt  = 1'b0;
    fol_evt_nxt = fol_evt_r;
    fol_air_nxt = fol_air_r;
    if (follow_r) begin
      evt_nxt = fol_evt_r;
      air_nxt = fol_air_r;
    end else if (tmo_ack) begin
      evt_nxt.valid  = 1'b1;
      evt_nxt.kind   = hes_pkg::EV_CONN_COMPLETE;
      evt_nxt.status = `HES_RS_HOST_TMO;
      air_nxt.valid  = 1'b1;
      air_nxt.reason = `HES_RS_HOST_TMO;
    end else if (take_link) begin
      evt_nxt = link_evt(link_in);
    end else if (take_cmd) begin
      evt_nxt.valid  = 1'b1;
      evt_nxt.status = verdict.code;
      unique case (verdict.route)
        hes_pkg::RT_DIRECT: begin
          evt_nxt.kind = verdict.use_cc ? hes_pkg::EV_CMD_COMPLETE
                                        : hes_pkg::EV_CMD_STATUS;
        end
        hes_pkg::RT_STATUS_THEN: begin
          evt_nxt.kind       = hes_pkg::EV_CMD_STATUS;
          evt_nxt.status     = `HES_ST_OK;
          follow_nxt         = 1'b1;
          fol_evt_nxt.valid  = 1'b1;
          fol_evt_nxt.kind   = verdict.follow_kind;
          fol_evt_nxt.status = verdict.follow_code;
          fol_air_nxt.valid  = verdict.air_valid;
          fol_air_nxt.reason = verdict.air_reason;
        end
        hes_pkg::RT_STATUS_OK: begin
          evt_nxt.kind = hes_pkg::EV_CMD_STATUS;
        end
        default: begin
          evt_nxt.kind   = hes_pkg::EV_CMD_STATUS;
          evt_nxt.status = `HES_ST_UNSPEC;
        end
      endcase
    end
  end

  // fair arbitration between host commands and link results
  assign free     = !follow_nxt && !tmo_req;
  assign sel_link = link_in.valid && (!cmd_in.valid || link_turn_r);

  // returned event and over-air reason registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evt_r <= '0;
      air_r <= '0;
    end else begin
      evt_r <= evt_nxt;
      air_r <= air_nxt;
    end
  end

  // second event of a two-step answer, held for one cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      follow_r  <= 1'b0;
      fol_evt_r <= '0;
      fol_air_r <= '0;
    end else begin
      follow_r  <= follow_nxt;
      fol_evt_r <= fol_evt_nxt;
      fol_air_r <= fol_air_nxt;
    end
  end

  // ready flags; never both high, dropped for a cycle after each take
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ready_r  <= 1'b0;
      link_ready_r <= 1'b0;
      link_turn_r  <= 1'b0;
    end else begin
      cmd_ready_r  <= free && !sel_link && cmd_in.valid && !take_cmd;
      link_ready_r <= free && sel_link && !take_link;
      if (take_cmd) begin
        link_turn_r <= 1'b1;
      end else if (take_link) begin
        link_turn_r <= 1'b0;
      end
    end
  end

  // mirror of the tracker's pending flag for the surrounding logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conn_pending_r <= 1'b0;
    end else begin
      conn_pending_r <= pending;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // restricted state answers a plain command with disallowed
  restrict_code_a: assert property (
    take_cmd && restricted && cmd_in.kind == hes_pkg::CK_OTHER
    |=> evt_r.valid && evt_r.status == `HES_ST_DISALLOWED
  ) else $error("restricted command not answered with disallowed");

  // disallowed error rides in command complete for such commands
  restrict_event_a: assert property (
    take_cmd && restricted && cmd_in.kind == hes_pkg::CK_OTHER &&
    cmd_in.cc_cmd
    |=> evt_r.kind == hes_pkg::EV_CMD_COMPLETE
  ) else $error("disallowed error not in command complete");

  // reset always succeeds in command complete
  reset_allowed_a: assert property (
    take_cmd && cmd_in.kind == hes_pkg::CK_RESET
    |=> evt_r.status == `HES_ST_OK &&
        evt_r.kind == hes_pkg::EV_CMD_COMPLETE
  ) else $error("reset command was refused");

  // connection limit errors now or after a zero status
  conn_limit_a: assert property (
    take_cmd && !follow_r && !tmo_ack && !take_link &&
    (verdict.code == `HES_ST_SCO_MAX ||
     verdict.code == `HES_ST_ACL_EXISTS)
    |=> (evt_r.kind == hes_pkg::EV_CMD_STATUS &&
         evt_r.status == $past(verdict.code)) or
        (evt_r.status == `HES_ST_OK ##1
         evt_r.kind == hes_pkg::EV_CONN_COMPLETE)
  ) else $error("connection limit code misplaced");

  // host reject reason follows a zero status and goes over the air
  reject_reason_a: assert property (
    take_cmd && !follow_r && cmd_in.kind == hes_pkg::CK_REJECT &&
    verdict.route == hes_pkg::RT_STATUS_THEN
    |=> evt_r.status == `HES_ST_OK ##1
        (evt_r.kind == hes_pkg::EV_CONN_COMPLETE &&
         evt_r.status == $past(cmd_in.reason, 2) &&
         air_r.valid && air_r.reason == evt_r.status)
  ) else $error("reject reason not returned");

  // accept timer expiry reaches the host within three cycles
  host_timeout_a: assert property (
    $rose(tmo_req)
    |-> ##[1:3] (evt_r.valid && evt_r.status == `HES_RS_HOST_TMO &&
                 air_r.reason == `HES_RS_HOST_TMO)
  ) else $error("host timeout not reported");

  // in-range but unsupported parameters
  unsupported_a: assert property (
    take_cmd && !restricted && !pending &&
    cmd_in.kind == hes_pkg::CK_OTHER && cmd_in.len_ok &&
    cmd_in.value_ok && !(cmd_in.needs_acl && cmd_in.handle_sco) &&
    !cmd_in.hw_ok
    |=> evt_r.status == `HES_ST_UNSUPPORTED
  ) else $error("unsupported value not reported");

  // wrong length yields invalid parameters
  bad_length_a: assert property (
    take_cmd && !restricted && !pending &&
    cmd_in.kind != hes_pkg::CK_RESET && !cmd_in.len_ok
    |=> evt_r.status == `HES_ST_INVALID &&
        (evt_r.kind == hes_pkg::EV_CMD_COMPLETE) == $past(cmd_in.cc_cmd)
  ) else $error("invalid length not reported");

  // SCO handle where ACL is needed
  sco_handle_a: assert property (
    take_cmd && !restricted && !pending &&
    cmd_in.kind == hes_pkg::CK_OTHER && cmd_in.len_ok &&
    cmd_in.value_ok && cmd_in.needs_acl && cmd_in.handle_sco
    |=> evt_r.status == `HES_ST_INVALID
  ) else $error("SCO handle accepted for ACL");

  // local disconnection always reports local termination
  disc_local_a: assert property (
    evt_r.valid && evt_r.kind == hes_pkg::EV_DISC_COMPLETE
    |-> evt_r.status == `HES_RS_LOCAL_TERM && air_r.valid &&
        $past(evt_r.kind) == hes_pkg::EV_CMD_STATUS
  ) else $error("disconnection complete carries wrong reason");

  // remote missing feature result
  remote_refuse_a: assert property (
    take_link && !follow_r && !tmo_ack &&
    link_in.kind == hes_pkg::LK_NO_FEATURE
    |=> evt_r.kind == hes_pkg::EV_ASSOC &&
        evt_r.status == `HES_ST_NO_RFEAT
  ) else $error("missing remote feature not reported");

  // remote LMP error codes pass through or fall back
  lmp_error_a: assert property (
    take_link && !follow_r && !tmo_ack &&
    link_in.kind == hes_pkg::LK_LMP_ERROR
    |=> evt_r.status == (($past(link_in.lmp_code) == `HES_ST_LMP_PARAM) ?
                          `HES_ST_LMP_PARAM : `HES_ST_UNSPEC)
  ) else $error("remote LMP error mapped wrongly");

endmodule
`default_nettype wire

// File: verif/hes_host_model.sv
// host side model that issues commands and holds them until taken
`default_nettype none
module hes_host_model (
  input  wire logic             clock,
  input  wire logic             cmd_ready_r,
  output var hes_pkg::hes_cmd_t cmd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_in = '0;
  // hold until a ready edge, then leave junk behind a low valid
  task automatic send(input hes_pkg::hes_cmd_t c);
    hes_pkg::hes_cmd_t junk;
    junk = ~c;
    junk.valid = 1'b0;
    c.valid = 1'b1;
    // one assignment per step: request and its qualifiers move together
    cmd_in = c;
    do @(posedge clock); while (cmd_ready_r !== 1'b1);
    @(negedge clock);
    cmd_in = junk;
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the status selector
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock, rst_b, restricted, sco_limit, acl_exists;
  logic               cmd_ready_r, link_ready_r, conn_pending_r;
  hes_pkg::hes_cmd_t  cmd_in, c;
  hes_pkg::hes_link_t link_in;
  hes_pkg::hes_evt_t  evt_r;
  hes_pkg::hes_air_t  air_r, last_air;
  int                 num_errors = 0, n_compared = 0, cycles = 0;
  hes_status_select #(.ACCEPT_CYCLES(8)) dut (
    .clock(clock), .rst_b(rst_b), .cmd_in(cmd_in),
    .cmd_ready_r(cmd_ready_r), .link_in(link_in),
    .link_ready_r(link_ready_r), .restricted(restricted),
    .sco_limit(sco_limit), .acl_exists(acl_exists), .evt_r(evt_r),
    .air_r(air_r), .conn_pending_r(conn_pending_r));
  hes_host_model host (.clock(clock), .cmd_ready_r(cmd_ready_r),
    .cmd_in(cmd_in));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bad(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // wait a bounded time for the next event and compare it
  task automatic cmp_evt(input hes_pkg::hes_evt_kind_t k,
                         input logic [7:0] s);
    for (int i = 0; i < 30 && evt_r.valid !== 1'b1; i++) @(negedge clock);
    last_air = air_r;
    bad({4'h0, evt_r.valid, evt_r.kind, evt_r.status}, {4'h0, 1'b1, k, s});
    @(negedge clock);
  endtask
  // reason sent to the remote side with the last event
  task automatic cmp_air(input logic [7:0] r);
    bad({7'h00, last_air}, {7'h00, 1'b1, r});
  endtask
  function automatic hes_pkg::hes_cmd_t mk(hes_pkg::hes_cmd_kind_t k,
                                           logic cc);
    mk = '0;
    mk.kind = k;
    mk.cc_cmd = cc;
    mk.len_ok = 1'b1;
    mk.value_ok = 1'b1;
    mk.hw_ok = 1'b1;
    mk.addr = 48'h0000_0000_1234;
  endfunction
  task automatic lnk(hes_pkg::hes_link_kind_t k, logic su, logic [7:0] v);
    link_in = '{1'b1, k, su, v, 48'h0000_0000_1234};
    do @(posedge clock); while (link_ready_r !== 1'b1);
    @(negedge clock);
    link_in = '0;
  endtask
  task automatic t_restrict();
    restricted = 1'b1;
    host.send(mk(hes_pkg::CK_RESET, 1'b1));
    cmp_evt(hes_pkg::EV_CMD_COMPLETE, 8'h00);
    host.send(mk(hes_pkg::CK_OTHER, 1'b1));
    cmp_evt(hes_pkg::EV_CMD_COMPLETE, 8'h0C);
    host.send(mk(hes_pkg::CK_OTHER, 1'b0));
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h0C);
    restricted = 1'b0;
  endtask
  task automatic t_params();
    sco_limit = 1'b1;
    host.send(mk(hes_pkg::CK_ADD_SCO, 1'b0));
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h0A);
    sco_limit = 1'b0;
    acl_exists = 1'b1;
    host.send(mk(hes_pkg::CK_CREATE, 1'b0));
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h0B);
    acl_exists = 1'b0;
    c = mk(hes_pkg::CK_OTHER, 1'b1);
    c.hw_ok = 1'b0;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_COMPLETE, 8'h11);
    c = mk(hes_pkg::CK_OTHER, 1'b1);
    c.len_ok = 1'b0;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_COMPLETE, 8'h12);
    c = mk(hes_pkg::CK_OTHER, 1'b0);
    c.needs_acl = 1'b1;
    c.handle_sco = 1'b1;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h12);
    c = mk(hes_pkg::CK_OTHER, 1'b0);
    c.exec_fail = 1'b1;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h1F);
  endtask
  task automatic t_disc(input logic [7:0] r);
    c = mk(hes_pkg::CK_DISCONNECT, 1'b0);
    c.reason = r;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h00);
    cmp_evt(hes_pkg::EV_DISC_COMPLETE, 8'h16);
    cmp_air(r);
  endtask
  task automatic t_reject(input logic [7:0] r);
    lnk(hes_pkg::LK_CONN_REQ, 1'b0, 8'h00);
    c = mk(hes_pkg::CK_RESPONSE, 1'b0);
    c.addr = 48'h0000_0000_9999;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h12);
    bad({15'h0000, conn_pending_r}, 16'h0001);
    c = mk(hes_pkg::CK_REJECT, 1'b0);
    c.reason = r;
    host.send(c);
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h00);
    cmp_evt(hes_pkg::EV_CONN_COMPLETE, r);
    cmp_air(r);
    bad({15'h0000, conn_pending_r}, 16'h0000);
  endtask
  task automatic t_link();
    // accepted request ends the pending state before the timer runs out
    lnk(hes_pkg::LK_CONN_REQ, 1'b0, 8'h00);
    host.send(mk(hes_pkg::CK_ACCEPT, 1'b0));
    cmp_evt(hes_pkg::EV_CMD_STATUS, 8'h00);
    bad({15'h0000, conn_pending_r}, 16'h0000);
    lnk(hes_pkg::LK_CONN_REQ, 1'b0, 8'h00);
    cmp_evt(hes_pkg::EV_CONN_COMPLETE, 8'h10);
    cmp_air(8'h10);
    lnk(hes_pkg::LK_REPEATED, 1'b1, 8'h00);
    cmp_evt(hes_pkg::EV_CONN_COMPLETE, 8'h17);
    lnk(hes_pkg::LK_PAIR_REFUSED, 1'b0, 8'h00);
    cmp_evt(hes_pkg::EV_AUTH_COMPLETE, 8'h18);
    lnk(hes_pkg::LK_NO_FEATURE, 1'b0, 8'h00);
    cmp_evt(hes_pkg::EV_ASSOC, 8'h1A);
    lnk(hes_pkg::LK_LMP_ERROR, 1'b0, 8'h20);
    cmp_evt(hes_pkg::EV_ASSOC, 8'h20);
    lnk(hes_pkg::LK_LMP_ERROR, 1'b0, 8'h05);
    cmp_evt(hes_pkg::EV_ASSOC, 8'h1F);
    lnk(hes_pkg::LK_DONE, 1'b0, 8'h00);
    cmp_evt(hes_pkg::EV_ASSOC, 8'h00);
  endtask
  initial begin
    rst_b = 1'b0;
    restricted = 1'b0;
    sco_limit = 1'b0;
    acl_exists = 1'b0;
    link_in = '0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    t_restrict();
    t_params();
    t_disc(8'h13);
    t_disc(8'h1A);
    for (int r = 13; r <= 15; r++) t_reject(8'(r));
    t_link();
    close_out();
  end
endmodule
`default_nettype wire
